// >>> hdl/scc_pkg.sv
// package: constants and types for the successive-approximation conversion control
package scc_pkg;
    localparam int unsigned CODE_WIDTH = 14; // result width in bits
    localparam logic [13:0] CODE_ZERO = 14'h0000; // code at zero input and underrange
    localparam logic [13:0] CODE_MID = 14'h2000; // code at half reference, msb trial
    localparam logic [13:0] CODE_FULL = 14'h3fff; // code at full scale and overrange
    localparam int unsigned CLK_PERIOD_NS = 10; // core clock period
    localparam int unsigned MIN_CYCLE_NS = 4000; // shortest cycle at 250 kSPS
    localparam int unsigned MIN_CYCLE_CLKS = (MIN_CYCLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [3:0] BIT_MSB = 4'hd; // index of the first trial bit
    localparam logic [3:0] BIT_LSB = 4'h0; // index of the last trial bit
    localparam logic [3:0] SER_LAST = 4'hd; // last shift position of readout

    // converter phases, gray coded along acquire -> release -> hold -> search -> finish
    typedef enum logic [2:0] {
        ST_ACQUIRE = 3'b000,
        ST_RELEASE = 3'b001,
        ST_HOLD = 3'b011,
        ST_SEARCH = 3'b010,
        ST_FINISH = 3'b110
    } scc_state_type;
endpackage : scc_pkg

// >>> hdl/scc_sar_control.sv
// module: control logic of a 14-bit charge redistribution successive-approximation converter
module scc_sar_control (
    input wire logic core_clk_i, // conversion clock, 100 MHz
    input wire logic rst_n_i, // synchronous reset, active low
    input wire logic convert_strobe_i, // host convert strobe
    input wire logic comp_high_i, // comparator: sample above trial level
    input wire logic over_range_i, // input difference above reference
    input wire logic under_range_i, // input difference below ground
    input wire logic sclk_i, // host serial clock, sampled synchronously
    output logic positive_array_ground_switch_o, // high: comparator side grounded
    output logic negative_array_ground_switch_o, // high: comparator side grounded
    output logic array_on_input_o, // high: arrays track the inputs
    output logic [13:0] dac_bits_o, // array elements on reference
    output logic powered_o, // analog core powered
    output logic busy_o, // conversion in progress
    output logic done_o, // one-cycle conversion complete pulse
    output logic [13:0] code_o, // latest result
    output logic serial_data_o // serial data, msb first
);
    // whole state in one struct
    // the readout fields run beside the conversion fields
    typedef struct packed {
        scc_pkg::scc_state_type state; // phase
        logic strobe_d; // strobe last cycle, edge detect
        logic sclk_d; // serial clock last cycle
        logic [13:0] trial; // trial register
        logic [3:0] bit_idx; // bit under test
        logic [3:0] decisions; // decisions taken this conversion
        logic over; // overrange caught at sample
        logic under; // underrange caught at sample
        logic [13:0] code; // output code
        logic [13:0] shreg; // readout shift register
        logic [3:0] ser_cnt; // bits shifted
        logic done; // done pulse
    } scc_reg_type;

    // registered state and the value it takes at the next edge
    scc_reg_type state_reg; // current state
    scc_reg_type state_next; // next state
    // edge strobes, valid for one cycle
    logic strobe_rise; // convert edge
    logic sclk_fall; // serial clock falling edge

    // one-hot mask of a bit index, used for trial set and keep
    // shared by the search logic and the trial checks below
    function automatic logic [13:0] bit_mask(input logic [3:0] idx);
        bit_mask = 14'h0001 << idx;
    endfunction : bit_mask

    // edge detectors; both delay flops reset low, the idle level of their pins,
    // so no false edge follows reset
    assign strobe_rise = convert_strobe_i & ~state_reg.strobe_d;
    assign sclk_fall = state_reg.sclk_d & ~sclk_i;

    // next state logic; every field but the edge history and done holds unless a branch below moves it
    always_comb begin
        state_next = state_reg; // hold by default
        state_next.strobe_d = convert_strobe_i; // history for the edge detectors
        state_next.sclk_d = sclk_i;
        state_next.done = 1'b0; // done is a pulse, cleared every cycle
        // readout runs independently of the conversion phase, so the host may
        // shift a result out while the next conversion is already under way
        // after the last shift the pin keeps showing the lsb
        if (sclk_fall && state_reg.ser_cnt != scc_pkg::SER_LAST) begin
            state_next.shreg = {state_reg.shreg[12:0], 1'b0};
            state_next.ser_cnt = state_reg.ser_cnt + 4'h1;
        end
        case (state_reg.state)
            scc_pkg::ST_ACQUIRE: begin
                // edges during conversion are ignored, host must wait
                // core powered down here, arrays track the inputs
                if (strobe_rise) begin
                    state_next.state = scc_pkg::ST_RELEASE;
                end
            end
            scc_pkg::ST_RELEASE: begin
                // ground switches open first, arrays still on the inputs
                // one full cycle gap keeps the two switch moves from overlapping
                state_next.state = scc_pkg::ST_HOLD;
            end
            scc_pkg::ST_HOLD: begin
                // arrays now on ground; range flags belong to this sample
                state_next.over = over_range_i;
                state_next.under = under_range_i;
                state_next.trial = scc_pkg::CODE_MID;
                state_next.bit_idx = scc_pkg::BIT_MSB;
                // fresh decision count for this sample
                state_next.decisions = 4'h0;
                state_next.state = scc_pkg::ST_SEARCH;
            end
            scc_pkg::ST_SEARCH: begin
                // keep trial bit if comparator says above, try next lower
                // the comparator is read once per cycle, one decision each
                if (!comp_high_i) begin
                    // sample below the trial level: drop the bit
                    state_next.trial = state_reg.trial & ~bit_mask(state_reg.bit_idx);
                end
                state_next.decisions = state_reg.decisions + 4'h1;
                if (state_reg.bit_idx == scc_pkg::BIT_LSB) begin
                    // lsb decided, the search is over
                    state_next.state = scc_pkg::ST_FINISH;
                end else begin
                    // settle the current bit and raise the next lower one together
                    state_next.bit_idx = state_reg.bit_idx - 4'h1;
                    state_next.trial = (comp_high_i ? state_reg.trial
                        : state_reg.trial & ~bit_mask(state_reg.bit_idx))
                        | bit_mask(state_reg.bit_idx - 4'h1);
                end
            end
            scc_pkg::ST_FINISH: begin
                // saturate then publish; no pipeline, same sample
                // over wins when both flags are set; the front end should never
                // raise both, so the order only matters for a faulty input
                if (state_reg.over) begin
                    state_next.code = scc_pkg::CODE_FULL;
                end else if (state_reg.under) begin
                    state_next.code = scc_pkg::CODE_ZERO;
                end else begin
                    state_next.code = state_reg.trial;
                end
                // load the readout from the new code so the msb shows with done
                state_next.shreg = state_next.code;
                state_next.ser_cnt = 4'h0;
                state_next.done = 1'b1;
                state_next.state = scc_pkg::ST_ACQUIRE;
            end
            default: begin
                state_next.state = scc_pkg::ST_ACQUIRE;
            end
        endcase
    end

    // state register, synchronous reset
    // the conversion is paced by this clock alone; the serial clock is only sampled
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            // readout counter starts exhausted so sclk edges do nothing before a result
            state_reg <= '{state: scc_pkg::ST_ACQUIRE, ser_cnt: scc_pkg::SER_LAST, default: '0};
        end else begin
            state_reg <= state_next;
        end
    end

    // outputs; switch controls decoded from the phase register
    assign positive_array_ground_switch_o = (state_reg.state == scc_pkg::ST_ACQUIRE);
    assign negative_array_ground_switch_o = (state_reg.state == scc_pkg::ST_ACQUIRE);
    // arrays stay on the inputs one cycle longer than the switches stay closed
    assign array_on_input_o = (state_reg.state == scc_pkg::ST_ACQUIRE)
        || (state_reg.state == scc_pkg::ST_RELEASE);
    // array elements only leave ground during the search
    assign dac_bits_o = (state_reg.state == scc_pkg::ST_SEARCH) ? state_reg.trial
        : scc_pkg::CODE_ZERO;
    // idle between conversions keeps the core dark, so power tracks rate
    assign powered_o = (state_reg.state != scc_pkg::ST_ACQUIRE);
    // busy mirrors the powered phases
    assign busy_o = powered_o;
    // data outputs straight from flip-flops
    assign done_o = state_reg.done;
    assign code_o = state_reg.code;
    assign serial_data_o = state_reg.shreg[13];

    // assertions; all run on the conversion clock and are off during reset
    // the strobe edge is sampled at its taking edge, done is seen 18 samples later
    // that is 17 clock cycles of conversion, far inside the 250 kSPS cycle
    property p_conv_len;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg.state == scc_pkg::ST_ACQUIRE && strobe_rise) |-> ##18 done_o;
    endproperty
    a_conv_len: assert property (p_conv_len) else $error("conversion length wrong");

    // a strobe edge in acquisition leaves acquisition on the very next cycle
    property p_start;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg.state == scc_pkg::ST_ACQUIRE && strobe_rise)
        |=> (state_reg.state == scc_pkg::ST_RELEASE) && busy_o;
    endproperty
    a_start: assert property (p_start) else $error("strobe edge ignored");

    // a running conversion is never restarted; host edges then are dropped
    property p_no_retrigger;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg.state != scc_pkg::ST_ACQUIRE)
        |=> (state_reg.state != scc_pkg::ST_RELEASE);
    endproperty
    a_no_retrigger: assert property (p_no_retrigger) else $error("conversion restarted");

    // ground switches open one cycle before the arrays leave the inputs
    property p_switch_first;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $fell(positive_array_ground_switch_o) |-> array_on_input_o ##1 !array_on_input_o;
    endproperty
    a_switch_first: assert property (p_switch_first) else $error("switch order wrong");

    // both comparator side switches move together
    property p_switch_pair;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        positive_array_ground_switch_o == negative_array_ground_switch_o;
    endproperty
    a_switch_pair: assert property (p_switch_pair) else $error("ground switches disagree");

    // the first trial is half reference, msb alone on the array
    property p_msb_first;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        $rose(state_reg.state == scc_pkg::ST_SEARCH) |-> dac_bits_o == scc_pkg::CODE_MID;
    endproperty
    a_msb_first: assert property (p_msb_first) else $error("msb trial wrong");

    // during search the bit under test is set and every lower bit is clear
    property p_trial_shape;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg.state == scc_pkg::ST_SEARCH)
        |-> ((dac_bits_o & bit_mask(state_reg.bit_idx)) != scc_pkg::CODE_ZERO)
        && ((dac_bits_o & (bit_mask(state_reg.bit_idx) - 14'h0001)) == scc_pkg::CODE_ZERO);
    endproperty
    a_trial_shape: assert property (p_trial_shape) else $error("trial word malformed");

    // each decision above the lsb is kept exactly when the comparator said above
    // checked on the word one cycle later, where the kept bit shows on the array
    property p_keep;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg.state == scc_pkg::ST_SEARCH && state_reg.bit_idx != scc_pkg::BIT_LSB)
        |=> ((dac_bits_o & bit_mask($past(state_reg.bit_idx))) != scc_pkg::CODE_ZERO)
            == $past(comp_high_i);
    endproperty
    a_keep: assert property (p_keep) else $error("trial bit decision wrong");

    // exactly fourteen decisions before the result is published
    property p_fourteen;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        done_o |-> state_reg.decisions == 4'he;
    endproperty
    a_fourteen: assert property (p_fourteen) else $error("decision count wrong");

    // the result appears back in acquisition with the core idle
    property p_done_acq;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        done_o |-> !busy_o && positive_array_ground_switch_o;
    endproperty
    a_done_acq: assert property (p_done_acq) else $error("not back in acquisition");

    // completion is a single cycle pulse
    property p_done_pulse;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        done_o |=> !done_o;
    endproperty
    a_done_pulse: assert property (p_done_pulse) else $error("done longer than one cycle");

    // the code only moves with done, so a read always sees one whole sample
    property p_code_hold;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        !done_o |-> $stable(code_o);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("code changed without done");

    // range flags caught in hold override the search, seen 16 samples later
    // a sample flagged both ways counts as over
    property p_over;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg.state == scc_pkg::ST_HOLD && over_range_i)
        |-> ##16 code_o == scc_pkg::CODE_FULL;
    endproperty
    a_over: assert property (p_over) else $error("overrange not saturated");
    property p_under;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        (state_reg.state == scc_pkg::ST_HOLD && under_range_i && !over_range_i)
        |-> ##16 code_o == scc_pkg::CODE_ZERO;
    endproperty
    a_under: assert property (p_under) else $error("underrange not saturated");

    // the core goes dark right after completion unless a new strobe arrives
    // checked one cycle on only, where power may return if a strobe edge came with done
    property p_power;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        done_o |-> !powered_o ##1 (!powered_o || $past(strobe_rise));
    endproperty
    a_power: assert property (p_power) else $error("core not powered down");

    // the msb of the new code is on the serial pin as soon as done shows
    property p_serial_msb;
        @(posedge core_clk_i) disable iff (!rst_n_i)
        done_o |-> serial_data_o == code_o[13];
    endproperty
    a_serial_msb: assert property (p_serial_msb) else $error("serial msb wrong");

    // main scenarios for coverage
    c_conv: cover property (@(posedge core_clk_i) done_o);
    c_over: cover property (@(posedge core_clk_i) done_o && code_o == scc_pkg::CODE_FULL);
    c_mid: cover property (@(posedge core_clk_i) done_o && code_o == scc_pkg::CODE_MID);
    c_under: cover property (@(posedge core_clk_i) done_o && code_o == scc_pkg::CODE_ZERO);
    c_retrigger: cover property (@(posedge core_clk_i)
        state_reg.state == scc_pkg::ST_SEARCH && strobe_rise);
endmodule : scc_sar_control

// >>> sim/scc_front_model.sv
// file: analog front end model facing the conversion control, ideal comparator
module scc_front_model (
    input wire logic [13:0] dac_bits_i, // trial word from the block
    input wire logic [14:0] level_i, // held sample, bit 14 set above reference
    input wire logic neg_i, // held sample below ground
    output logic comp_high_o, // sample at or above trial level
    output logic over_range_o, // input above reference
    output logic under_range_o // input below ground
);
    timeunit 1ns;
    timeprecision 1ps;
    // ideal comparator; a sample below ground never reaches any trial level
    assign comp_high_o = !neg_i && (level_i >= {1'b0, dac_bits_i});
    // range flags follow the held sample, no filtering
    assign over_range_o = level_i[14];
    assign under_range_o = neg_i;
endmodule : scc_front_model

// >>> sim/scc_sar_control_tb_top.sv
// file: self-checking bench for the successive-approximation conversion control
module scc_sar_control_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0; // core clock
    logic rst_n = 1'b0; // reset, active low
    logic strobe = 1'b0; // convert strobe
    logic sclk = 1'b0; // serial clock, idle low
    logic [14:0] level = 15'h0000; // held sample
    logic neg = 1'b0; // sample below ground
    logic comp_high, over_range, under_range, sw_pos, sw_neg, on_input, powered, busy, done, sdo;
    logic [13:0] dac, code;
    logic [13:0] tbl [6] = '{14'h0000, 14'h2000, 14'h3fff, 14'h1fff, 14'h2001, 14'h0001};
    int fail_count = 0; // mismatches
    int n_tests = 0; // comparisons
    int cycles = 0; // hang guard
    // free running clock
    always #5 clk = ~clk;
    scc_sar_control u_dut (.core_clk_i(clk), .rst_n_i(rst_n), .convert_strobe_i(strobe),
        .comp_high_i(comp_high), .over_range_i(over_range), .under_range_i(under_range),
        .sclk_i(sclk), .positive_array_ground_switch_o(sw_pos),
        .negative_array_ground_switch_o(sw_neg), .array_on_input_o(on_input),
        .dac_bits_o(dac), .powered_o(powered), .busy_o(busy), .done_o(done), .code_o(code),
        .serial_data_o(sdo));
    scc_front_model u_front (.dac_bits_i(dac), .level_i(level), .neg_i(neg),
        .comp_high_o(comp_high), .over_range_o(over_range), .under_range_o(under_range));
    // one comparison, reported at once on mismatch
    task automatic chk(input logic [13:0] got, input logic [13:0] exp);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // one conversion with a retrigger attempt in mid-search, timed from the strobe edge
    task automatic conv(input logic [14:0] lv, input logic nv, input logic [13:0] exp);
        int done_at;
        done_at = 0;
        @(posedge clk);
        level <= lv;
        neg <= nv;
        strobe <= 1'b1;
        for (int n = 1; n <= 20; n++) begin
            @(posedge clk);
            if (n == 2) strobe <= 1'b0;
            if (n == 6) strobe <= 1'b1;
            if (n == 8) strobe <= 1'b0;
            #1;
            if (n == 2) chk({10'h000, busy, powered, sw_pos, sw_neg}, 14'h000c);
            if (n == 3) chk({13'h0000, on_input}, 14'h0000);
            if (n == 3) chk(dac, scc_pkg::CODE_MID);
            if (done === 1'b1) done_at = (done_at == 0) ? n : 99;
            if (n == 18) chk(code, exp);
            if (n == 18) chk({12'h000, busy, sdo}, {13'h0000, exp[13]});
        end
        chk(done_at[13:0], 14'h0012);
        chk({12'h000, powered, sw_pos}, 14'h0001);
    endtask : conv
    // shift the whole result out, msb first, then expect the last bit to hold
    task automatic read_out(input logic [13:0] exp);
        for (int k = 0; k < 14; k++) begin
            chk({13'h0000, sdo}, {13'h0000, exp[13 - k]});
            @(posedge clk);
            sclk <= 1'b1;
            repeat (2) @(posedge clk);
            sclk <= 1'b0;
            repeat (3) @(posedge clk);
            #1;
        end
        chk({13'h0000, sdo}, {13'h0000, exp[0]});
    endtask : read_out
    // closing report, the single place the run ends
    task automatic results();
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : results
    // hang guard, far beyond the few hundred cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            fail_count++;
            results();
        end
    end
    // main sequence
    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        #1;
        chk(code, scc_pkg::CODE_ZERO);
        chk({12'h000, sw_pos, busy}, 14'h0002);
        // straight binary codes across the range, back to back
        foreach (tbl[i]) conv({1'b0, tbl[i]}, 1'b0, tbl[i]);
        conv(15'h4001, 1'b0, scc_pkg::CODE_FULL);
        conv(15'h3000, 1'b1, scc_pkg::CODE_ZERO);
        conv({1'b0, 14'h2c35}, 1'b0, 14'h2c35);
        read_out(14'h2c35);
        results();
    end
endmodule : scc_sar_control_tb_top
